// ---- lcdtpc_core.sv ----
// LCD display timing, latch, common scan and power control with Wishbone registers
// Functional notes
// [R01] Master drives polarity, frame align, clocks
// [R02] Slave takes polarity, frame align; clock floats
// [R03] Software loads n minus one for n-line
// [R04] 167 outputs: 70 segment, 96 dual, one
// [R05] Two shift registers scan the commons
// [R06] Four levels from data, scan, polarity
// [R07] Line latch per period; display modes there
// [R08] Oscillator only used in master mode
// [R09] Oscillator divided by four, eight, sixteen
// [R10] Power circuit works only in master
// [R11] Power off disables all three stages
// [R12] Host waits settling before completion command
// [R13] Mode pins decode the three power stages
// [R14] Tripler clocked from running oscillator
// [R15] Five-bit contrast register, 32 steps
// [R16] Zero contrast disables current contribution
// [R17] Each step adds one thirty-first current
// [R18] Software enables regulator and follower first
// [R19] Frame start loads line counter, then increments
// [R20] Start pulse before frame-align change, both modes; master raises it in the same cycle as the change
// [R21] Polarity toggles per frame by default
// [R22] N-line mode toggles after n lines
//
// Implementation choices: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
`include "lcdtpc_map.svh"
module lcdtpc_core
  import lcdtpc_pkg::*;
(
  input  wire logic               I_CORE_CLK,
  input  wire logic               I_RST_N,
  input  wire logic               I_WB_CYC,
  input  wire logic               I_WB_STB,
  input  wire logic               I_WB_WE,
  input  wire logic [7:0]         I_WB_ADR,
  input  wire logic [3:0]         I_WB_SEL,
  input  wire logic [31:0]        I_WB_DAT,
  output logic      [31:0]        O_WB_DAT,
  output logic                    O_WB_ACK,
  input  wire logic               I_OSC_TICK,
  input  wire logic               I_LINE_TICK_IN,
  input  wire logic               I_AC_DRIVE_POLARITY,
  input  wire logic               I_FRAME_ALIGN,
  input  wire logic               I_POWER_CFG_SEL_A,
  input  wire logic               I_POWER_CFG_SEL_B,
  output logic                    O_AC_DRIVE_POLARITY,
  output logic                    O_AC_DRIVE_POLARITY_OE_N,
  output logic                    O_FRAME_ALIGN,
  output logic                    O_FRAME_ALIGN_OE_N,
  output logic                    O_DIVIDED_TICK_OUT,
  output logic                    O_DIVIDED_TICK_OUT_OE_N,
  output logic                    O_COMMON_START_PULSE,
  output logic                    O_LINE_REQ,
  output logic [5:0]              O_LINE_ADDR,
  output logic                    O_TRIPLER_EN,
  output logic                    O_TRIPLER_CLK,
  output logic                    O_REGULATOR_EN,
  output logic                    O_FOLLOWER_EN,
  output logic                    O_CURRENT_EN,
  output logic [4:0]              O_CURRENT_STEPS,
  output lcdtpc_lvl_t             O_DRIVE_LVL [`LCDTPC_OUTS]
);
  logic [7:0]  ctrl;
  logic [5:0]  init_line;
  logic [5:0]  nline;
  logic [4:0]  volume;
  logic [`LCDTPC_ROW_BITS-1:0] row_buf;
  logic [`LCDTPC_ROW_BITS-1:0] row_latch;
  logic [3:0]  div_cnt;
  logic        osc_q;
  logic        div_q;
  logic [6:0]  line_in_frame;
  logic [5:0]  nl_cnt;
  logic        pol_int;
  logic        frame_int;
  logic [5:0]  line_cnt;
  logic [47:0] scan_lo;
  logic [47:0] scan_hi;
  logic        is_master;
  logic        pwr_ok;
  logic        osc_rise;
  logic        line_tick;
  logic        pol_now;
  logic        frame_now;
  logic        frame_q;
  logic        frame_edge;
  logic        last_line;
  logic        wb_req;
  logic [3:0]  div_mask;
  logic [`LCDTPC_DUAL:0] com_sel;
  logic [`LCDTPC_DUAL:0] is_com;
  logic [`LCDTPC_ROW_BITS-1:0] row_shown;

  assign is_master = ctrl[`LCDTPC_CTRL_MASTER];
  assign wb_req    = I_WB_CYC && I_WB_STB && !O_WB_ACK;

  // Wishbone slave: one registered ack a cycle after the strobe, unmapped reads give zero
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      O_WB_ACK <= 1'b0;
    end else begin
      O_WB_ACK <= wb_req;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      ctrl      <= `LCDTPC_CTRL_RST;
      init_line <= 6'h00;
      nline     <= 6'h00;
      volume    <= `LCDTPC_VOL_RST;
      row_buf   <= '0;
    end else if (wb_req && I_WB_WE && I_WB_SEL[0]) begin
      unique case (I_WB_ADR)
        `LCDTPC_ADR_CTRL:      ctrl <= I_WB_DAT[7:0];
        `LCDTPC_ADR_INIT_LINE: init_line <= I_WB_DAT[5:0];
        `LCDTPC_ADR_NLINE:     nline <= I_WB_DAT[5:0]; // see [R03]
        `LCDTPC_ADR_VOLUME:    volume <= I_WB_DAT[4:0]; // see [R15]
        `LCDTPC_ADR_ROWDATA:   row_buf <= {row_buf[`LCDTPC_ROW_BITS-33:0], I_WB_DAT};
        default: ;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      O_WB_DAT <= 32'h0000_0000;
    end else if (wb_req && !I_WB_WE) begin
      unique case (I_WB_ADR)
        `LCDTPC_ADR_CTRL:      O_WB_DAT <= {24'h00_0000, ctrl};
        `LCDTPC_ADR_INIT_LINE: O_WB_DAT <= {26'h000_0000, init_line};
        `LCDTPC_ADR_NLINE:     O_WB_DAT <= {26'h000_0000, nline};
        `LCDTPC_ADR_VOLUME:    O_WB_DAT <= {27'h000_0000, volume};
        `LCDTPC_ADR_STATUS:    O_WB_DAT <= {16'h0000, pol_now, frame_now, O_TRIPLER_EN,
                                            O_REGULATOR_EN, O_FOLLOWER_EN, 5'h00, line_cnt};
        default:               O_WB_DAT <= 32'h0000_0000;
      endcase
    end
  end

  // Divider: oscillator only counted in master mode
  always_comb begin
    unique case (lcdtpc_div_e'(ctrl[`LCDTPC_CTRL_DUTY_LSB +: 2]))
      LCDTPC_DIV4:  div_mask = 4'h1;
      LCDTPC_DIV8:  div_mask = 4'h3;
      LCDTPC_DIV16: div_mask = 4'h7;
      default:      div_mask = 4'h1;
    endcase
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      osc_q   <= 1'b0;
      div_cnt <= 4'h0;
      div_q   <= 1'b0;
    end else begin
      osc_q <= I_OSC_TICK;
      if (osc_rise && is_master) begin // see [R08]
        if ((div_cnt & div_mask) == div_mask) begin
          div_cnt <= 4'h0;
          div_q   <= ~div_q; // see [R09]
        end else begin
          div_cnt <= div_cnt + 4'h1;
        end
      end
    end
  end
  assign osc_rise = I_OSC_TICK && !osc_q;

  // Line tick: internal divider in master, external line clock in slave
  logic div_q_d;
  logic line_in_q;
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      div_q_d   <= 1'b0;
      line_in_q <= 1'b0;
    end else begin
      div_q_d   <= div_q;
      line_in_q <= I_LINE_TICK_IN;
    end
  end
  assign line_tick = is_master ? (div_q && !div_q_d) : (I_LINE_TICK_IN && !line_in_q);

  // Frame timing: line count runs in both modes, realigned to the frame edge in slave
  assign last_line = (line_in_frame == `LCDTPC_LINES_PER_FRAME - 7'h01);
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      line_in_frame <= 7'h00;
      frame_int     <= 1'b0;
    end else if (frame_edge && !is_master) begin
      line_in_frame <= 7'h00; // Slave realigns to the master frame; see [R20]
    end else if (line_tick) begin
      line_in_frame <= last_line ? 7'h00 : line_in_frame + 7'h01;
      if (last_line) begin
        frame_int <= ~frame_int;
      end
    end
  end

  // Start pulse on the last-line tick: with the frame-align change in master, before it in slave
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      O_COMMON_START_PULSE <= 1'b0;
    end else if (line_tick) begin
      O_COMMON_START_PULSE <= last_line; // see [R20]
    end
  end

  assign frame_now = is_master ? frame_int : I_FRAME_ALIGN; // see [R02]
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      frame_q <= 1'b0;
    end else begin
      frame_q <= frame_now;
    end
  end
  assign frame_edge = frame_now ^ frame_q;

  // Polarity: per frame, or every nline+1 lines restarted at frame
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      pol_int <= 1'b0;
      nl_cnt  <= 6'h00;
    end else if (frame_edge) begin
      nl_cnt <= 6'h00; // see [R22]
      if (!ctrl[`LCDTPC_CTRL_NLINE_EN]) begin
        pol_int <= ~pol_int; // see [R21]
      end
    end else if (line_tick && ctrl[`LCDTPC_CTRL_NLINE_EN]) begin
      if (nl_cnt == nline) begin
        nl_cnt  <= 6'h00;
        pol_int <= ~pol_int; // see [R22]
      end else begin
        nl_cnt <= nl_cnt + 6'h01;
      end
    end
  end
  assign pol_now = is_master ? pol_int : I_AC_DRIVE_POLARITY;

  // Pin directions; enable low while driving
  always_comb begin
    O_AC_DRIVE_POLARITY      = pol_int;
    O_FRAME_ALIGN            = frame_int;
    O_DIVIDED_TICK_OUT       = div_q;
    O_AC_DRIVE_POLARITY_OE_N = !is_master; // see [R01]
    O_FRAME_ALIGN_OE_N       = !is_master; // see [R01]
    O_DIVIDED_TICK_OUT_OE_N  = !is_master; // see [R02]
  end

  // Line counter and row latch
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      line_cnt  <= 6'h00;
      row_latch <= '0;
    end else if (frame_edge) begin
      line_cnt <= init_line; // see [R19]
    end else if (line_tick) begin
      line_cnt  <= line_cnt + 6'h01; // see [R19]
      row_latch <= row_buf; // see [R07]
    end
  end
  assign O_LINE_ADDR = line_cnt;
  assign O_LINE_REQ  = line_tick;

  // Display modes act on the latch only, RAM buffer is untouched
  always_comb begin
    if (ctrl[`LCDTPC_CTRL_ALL_ON]) begin
      row_shown = '1; // see [R07]
    end else if (!ctrl[`LCDTPC_CTRL_DISP_ON]) begin
      row_shown = '0;
    end else begin
      row_shown = ctrl[`LCDTPC_CTRL_INVERSE] ? ~row_latch : row_latch;
    end
  end

  // Two common scan shift registers, one per dual bank
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      scan_lo <= '0;
      scan_hi <= '0;
    end else if (line_tick) begin
      scan_lo <= {scan_lo[46:0], O_COMMON_START_PULSE}; // see [R05]
      scan_hi <= {scan_lo[47], scan_hi[47:1]}; // see [R05]
    end
  end
  assign com_sel = {frame_now && line_in_frame == 7'h00, scan_hi, scan_lo};
  assign is_com  = {1'b1, {`LCDTPC_DUAL{1'b1}}};

  lcdtpc_out_drv u_drv (
    .I_CORE_CLK (I_CORE_CLK),
    .I_RST_N    (I_RST_N),
    .i_row      (row_shown),
    .i_com_sel  (com_sel),
    .i_is_com   (is_com),
    .i_pol      (pol_now),
    .o_lvl      (O_DRIVE_LVL) // see [R04]
  );

  // Power stages: master only, off command kills all
  assign pwr_ok = is_master && ctrl[`LCDTPC_CTRL_PWR_ON]; // see [R10] [R11]
  always_comb begin
    O_TRIPLER_EN   = pwr_ok && !I_POWER_CFG_SEL_A; // see [R13]
    O_REGULATOR_EN = pwr_ok && !(I_POWER_CFG_SEL_A && I_POWER_CFG_SEL_B); // see [R13]
    O_FOLLOWER_EN  = pwr_ok;
    O_TRIPLER_CLK  = O_TRIPLER_EN && I_OSC_TICK; // see [R14]
    O_CURRENT_EN   = (volume != 5'h00) && O_REGULATOR_EN; // see [R16]
    O_CURRENT_STEPS = volume; // see [R17]
  end

  AST_SLAVE_FLOAT: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // see [R02]
    !is_master |-> O_DIVIDED_TICK_OUT_OE_N && O_AC_DRIVE_POLARITY_OE_N)
    else $error("slave drives clock");
  AST_MASTER_DRV: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // see [R01]
    is_master |-> !O_FRAME_ALIGN_OE_N && !O_DIVIDED_TICK_OUT_OE_N)
    else $error("master not driving");
  AST_PWR_OFF: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // see [R11]
    !ctrl[`LCDTPC_CTRL_PWR_ON] |-> !O_TRIPLER_EN && !O_REGULATOR_EN && !O_FOLLOWER_EN)
    else $error("power stage on while off");
  AST_HH_MODE: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // see [R13]
    pwr_ok && I_POWER_CFG_SEL_A && I_POWER_CFG_SEL_B |-> !O_REGULATOR_EN && O_FOLLOWER_EN)
    else $error("hh decode wrong");
  AST_SLAVE_PWR: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // see [R10]
    !is_master |-> !O_FOLLOWER_EN)
    else $error("slave power on");
  AST_VOL_ZERO: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // see [R16]
    volume == 5'h00 |-> !O_CURRENT_EN)
    else $error("current on at zero");
  AST_LINE_LOAD: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // see [R19]
    frame_edge |=> line_cnt == $past(init_line))
    else $error("line counter not loaded");
  AST_NL_RESTART: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // see [R22]
    frame_edge |=> nl_cnt == 6'h00)
    else $error("n-line count not restarted");
  AST_NO_OSC_SLAVE: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // see [R08]
    !is_master && $stable(is_master) |=> $stable(div_cnt))
    else $error("slave divider ran");
  AST_TRIP_CLK: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N) // see [R14]
    !O_TRIPLER_EN |-> !O_TRIPLER_CLK)
    else $error("tripler clock without enable");
endmodule // lcdtpc_core

// ---- lcdtpc_map.svh ----
// Constants for the LCD drive timing and power control block
`ifndef LCDTPC_MAP_SVH
`define LCDTPC_MAP_SVH
`define LCDTPC_ADR_CTRL      8'h00
`define LCDTPC_ADR_INIT_LINE 8'h04
`define LCDTPC_ADR_NLINE     8'h08
`define LCDTPC_ADR_VOLUME    8'h0c
`define LCDTPC_ADR_STATUS    8'h10
`define LCDTPC_ADR_ROWDATA   8'h14
`define LCDTPC_CTRL_MASTER   0
`define LCDTPC_CTRL_PWR_ON   1
`define LCDTPC_CTRL_NLINE_EN 2
`define LCDTPC_CTRL_INVERSE  3
`define LCDTPC_CTRL_DISP_ON  4
`define LCDTPC_CTRL_ALL_ON   5
`define LCDTPC_CTRL_DUTY_LSB 6
`define LCDTPC_CTRL_RST      8'h00
`define LCDTPC_VOL_RST       5'h00
`define LCDTPC_VOL_STEPS     6'h1f
`define LCDTPC_LINES_PER_FRAME 7'h40
`define LCDTPC_SEG_ONLY      70
`define LCDTPC_DUAL          96
`define LCDTPC_OUTS          167
`define LCDTPC_ROW_BITS      166
`endif

// ---- lcdtpc_pkg.sv ----
// Types for the LCD drive timing and power control block
package lcdtpc_pkg;
  typedef enum logic [1:0] {
    LCDTPC_DIV4  = 2'h0,
    LCDTPC_DIV8  = 2'h1,
    LCDTPC_DIV16 = 2'h3
  } lcdtpc_div_e;
  typedef logic [1:0] lcdtpc_lvl_t;
endpackage

// ---- lcdtpc_out_drv.sv ----
// Per-output four-level drive selection
`timescale 1ns/100ps
`include "lcdtpc_map.svh"
module lcdtpc_out_drv
  import lcdtpc_pkg::*;
(
  input  wire logic                         I_CORE_CLK,
  input  wire logic                         I_RST_N,
  input  wire logic [`LCDTPC_ROW_BITS-1:0]  i_row,
  input  wire logic [`LCDTPC_DUAL:0]        i_com_sel,
  input  wire logic [`LCDTPC_DUAL:0]        i_is_com,
  input  wire logic                         i_pol,
  output lcdtpc_lvl_t                       o_lvl [`LCDTPC_OUTS]
);
  // Level code: {active, pol xor active}; segment bit selects select/nonselect
  genvar g;
  generate
    for (g = 0; g < `LCDTPC_OUTS; g++) begin : g_out
      logic on;
      if (g < `LCDTPC_DUAL + 1) begin : g_dual
        assign on = i_is_com[g] ? i_com_sel[g] : ((g < `LCDTPC_ROW_BITS) ? i_row[g] : 1'b0);
      end else begin : g_seg
        assign on = i_row[g-`LCDTPC_DUAL-1];
      end
      always_ff @(posedge I_CORE_CLK) begin
        if (!I_RST_N) begin
          o_lvl[g] <= 2'h0;
        end else begin
          o_lvl[g] <= {on, i_pol ^ on}; // see [R06]
        end
      end
    end
  endgenerate
endmodule // lcdtpc_out_drv

// ---- lcdtpc_ext_mstr.sv ----
// Model of the cascaded master chip feeding a slave driver
`timescale 1ns/100ps
module lcdtpc_ext_mstr (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  input  wire logic i_en,
  output logic      o_line_tick,
  output logic      o_frame_align,
  output logic      o_polarity
);
  logic [2:0] ph;
  logic [5:0] line;
  // Line clock stands still while disabled
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !i_en) begin
      ph          <= 3'h0;
      line        <= 6'h00;
      o_line_tick <= 1'b0;
    end else begin
      ph          <= ph + 3'h1;
      o_line_tick <= (ph == 3'h7);
      if (ph == 3'h7) begin
        line <= line + 6'h01;
      end
    end
  end
  // Frame edge mid-line, away from the tick; polarity per frame
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_frame_align <= 1'b0;
      o_polarity    <= 1'b0;
    end else if (i_en && ph == 3'h3 && line == 6'h3f) begin
      o_frame_align <= ~o_frame_align;
      o_polarity    <= ~o_polarity;
    end
  end
endmodule // lcdtpc_ext_mstr

// ---- tb.sv ----
// Register-level testbench for the LCD timing and power block
`timescale 1ns/100ps
`include "lcdtpc_map.svh"
module tb;
  import lcdtpc_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        ack, osc = 1'b0, sa = 1'b0, sb = 1'b0, m_en = 1'b0;
  logic        lt, fa, pol;
  logic        o_pol, o_pol_oe_n, o_fa, o_fa_oe_n, o_div, o_div_oe_n, o_csp, o_lreq;
  logic [5:0]  o_laddr;
  logic        o_tri, o_tclk, o_reg, o_fol, o_cur;
  logic [4:0]  o_steps;
  lcdtpc_lvl_t drv [`LCDTPC_OUTS];
  int          error_cnt = 0, checks_done = 0, cyc_cnt = 0, n, m;

  always #12.5 clk = ~clk;
  always @(posedge clk) osc <= ~osc;

  lcdtpc_core u_lcdtpc_core (.I_CORE_CLK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc),
    .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
    .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_OSC_TICK(osc), .I_LINE_TICK_IN(lt),
    .I_AC_DRIVE_POLARITY(pol), .I_FRAME_ALIGN(fa), .I_POWER_CFG_SEL_A(sa),
    .I_POWER_CFG_SEL_B(sb), .O_AC_DRIVE_POLARITY(o_pol),
    .O_AC_DRIVE_POLARITY_OE_N(o_pol_oe_n), .O_FRAME_ALIGN(o_fa),
    .O_FRAME_ALIGN_OE_N(o_fa_oe_n), .O_DIVIDED_TICK_OUT(o_div),
    .O_DIVIDED_TICK_OUT_OE_N(o_div_oe_n), .O_COMMON_START_PULSE(o_csp),
    .O_LINE_REQ(o_lreq), .O_LINE_ADDR(o_laddr), .O_TRIPLER_EN(o_tri),
    .O_TRIPLER_CLK(o_tclk), .O_REGULATOR_EN(o_reg), .O_FOLLOWER_EN(o_fol),
    .O_CURRENT_EN(o_cur), .O_CURRENT_STEPS(o_steps), .O_DRIVE_LVL(drv));

  lcdtpc_ext_mstr u_lcdtpc_ext_mstr (.i_clk(clk), .i_rst_n(rst_n), .i_en(m_en),
    .o_line_tick(lt), .o_frame_align(fa), .o_polarity(pol));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // One classic cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'hf;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk);
  endtask

  // Line requests between two polarity changes
  task automatic pol_span(output int cnt);
    logic last;
    @(posedge clk);
    last = o_pol;
    do @(posedge clk); while (o_pol === last);
    last = o_pol;
    cnt  = 0;
    do begin
      @(posedge clk);
      if (o_lreq === 1'b1) cnt++;
    end while (o_pol === last);
  endtask

  task automatic pwr_chk(input logic [2:0] exp);
    repeat (2) @(posedge clk);
    chk({29'h0, o_tri, o_reg, o_fol}, {29'h0, exp});
  endtask

  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 60000) begin
      error_cnt++;
      final_report();
    end
  end

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({o_pol_oe_n, o_fa_oe_n, o_div_oe_n}, 3'h7);
    wb(1'b0, `LCDTPC_ADR_CTRL, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, 8'h20, 32'h0);
    chk(q, 32'h0);
    // Slave timing from the partner
    wb(1'b1, `LCDTPC_ADR_INIT_LINE, 32'h5);
    wb(1'b1, `LCDTPC_ADR_CTRL, 32'h12);
    pwr_chk(3'h0);
    m_en <= 1'b1;
    @(fa);
    repeat (2) @(posedge clk);
    chk(o_laddr, 6'h05);
    @(posedge lt);
    repeat (2) @(posedge clk);
    chk(o_laddr, 6'h06);
    // One start pulse per frame, still high when frame align flips
    @(fa);
    n = 0;
    q[0] = fa;
    q[1] = o_csp;
    while (fa === q[0]) begin
      @(posedge clk);
      if (o_csp === 1'b1 && q[1] !== 1'b1) n++;
      q[1] = o_csp;
    end
    chk(n, 1);
    chk(o_csp, 1'b1);
    chk({o_pol_oe_n, o_fa_oe_n, o_div_oe_n}, 3'h7);
    wb(1'b0, `LCDTPC_ADR_STATUS, 32'h0);
    chk(q[15:14], {pol, fa});
    m_en <= 1'b0;
    // Master with internal power, all four mode-pin settings decoded
    wb(1'b1, `LCDTPC_ADR_CTRL, 32'h13);
    chk({o_pol_oe_n, o_fa_oe_n, o_div_oe_n}, 3'h0);
    for (int i = 0; i < 4; i++) begin
      {sa, sb} <= i[1:0];
      pwr_chk((i == 3) ? 3'h1 : (i == 2) ? 3'h3 : 3'h7);
    end
    {sa, sb} <= 2'h0;
    repeat (3) @(posedge clk); // Settling wait after power on
    chk(o_tclk, osc & o_tri);
    wb(1'b1, `LCDTPC_ADR_VOLUME, 32'h1f);
    wb(1'b0, `LCDTPC_ADR_VOLUME, 32'h0);
    chk(q, 32'h1f);
    chk({o_cur, o_steps}, 6'h3f);
    wb(1'b1, `LCDTPC_ADR_VOLUME, 32'h0);
    chk(o_cur, 1'b0);
    // Row bit 0 feeds the first segment-only output
    wb(1'b1, `LCDTPC_ADR_ROWDATA, 32'h1);
    repeat (20) @(posedge clk);
    chk({drv[97][1], drv[98][1]}, 2'h2);
    wb(1'b1, `LCDTPC_ADR_CTRL, 32'h1b);
    repeat (2) @(posedge clk);
    chk({drv[97][1], drv[98][1]}, 2'h1);
    wb(1'b1, `LCDTPC_ADR_CTRL, 32'h33);
    repeat (2) @(posedge clk);
    chk({drv[97][1], drv[98][1]}, 2'h3);
    wb(1'b1, `LCDTPC_ADR_CTRL, 32'h03);
    repeat (2) @(posedge clk);
    chk({drv[97][1], drv[98][1]}, 2'h0);
    wb(1'b1, `LCDTPC_ADR_CTRL, 32'h13);
    repeat (2) @(posedge clk);
    chk({drv[97][1], drv[98][1]}, 2'h2);
    pol_span(n);
    chk(n, `LCDTPC_LINES_PER_FRAME);
    wb(1'b1, `LCDTPC_ADR_NLINE, 32'h4);
    wb(1'b1, `LCDTPC_ADR_CTRL, 32'h17);
    @(o_fa);
    pol_span(n);
    chk(n, 5);
    @(o_fa);
    n = 0;
    repeat (200) begin
      @(posedge clk);
      if (o_lreq === 1'b1) n++;
    end
    for (int d = 1; d < 4; d = d + 2) begin
      wb(1'b1, `LCDTPC_ADR_CTRL, {24'h0, d[1:0], 6'h13});
      m = 0;
      repeat (200) begin
        @(posedge clk);
        if (o_lreq === 1'b1) m++;
      end
      chk(m < n, 1'b1);
      n = m;
    end
    wb(1'b1, `LCDTPC_ADR_CTRL, 32'h01);
    pwr_chk(3'h0);
    final_report();
  end
endmodule // tb
